// File: design/sbcd_pkg.sv
/*
 * Package for the synchronous burst SRAM cycle decoder.
 * Holds lane and address widths, reset values and the cycle enumeration.
 * Assumes a single 250 MHz clock and no software-visible registers.
 */
package sbcd_pkg;
   // Byte lanes of the widest variant; narrower parts use the low lanes
   localparam int SBCD_LANES = 8;
   // Burst counter covers the two lowest address bits
   localparam int SBCD_ADDR_W = 2;
   // Reset values and the all-lanes write mask
   localparam logic [SBCD_ADDR_W-1:0] SBCD_ADDR_RST = 2'h0;
   localparam logic [SBCD_LANES-1:0] SBCD_LANES_RST = 8'h00;
   localparam logic [SBCD_LANES-1:0] SBCD_LANES_ALL = 8'hFF;
   // Clock period in ns, for reference by timing users
   localparam int SBCD_CLOCK_NS = 4;

   // Kind of cycle in effect after a clock edge
   typedef enum logic [1:0] {
      SBCD_IDLE,
      SBCD_READ,
      SBCD_WRITE
   } sbcd_cycle_t;
endpackage

// File: design/sbcd_burst_if.sv
/*
 * Interface between the cycle decoder and its burst address counter.
 * Assumes both ends share the decoder clock.
 */
`timescale 1ns/1ps
interface sbcd_burst_if;
   import sbcd_pkg::*;
   logic load;                        // Take a new start address
   logic step;                        // Move to the next burst address
   logic linear;                      // Linear order when high, interleaved when low
   logic [SBCD_ADDR_W-1:0] start;     // External A1:A0
   logic [SBCD_ADDR_W-1:0] addr;      // Address in effect next cycle

   modport ctrl (output load, output step, output linear, output start, input addr);
   modport cnt (input load, input step, input linear, input start, output addr);
endinterface

// File: design/sbcd_burst_counter.sv
/*
 * Two-bit wraparound burst counter, interleaved or linear.
 * Assumes load and step are never high together in a way that matters: load wins.
 */
`timescale 1ns/1ps
module sbcd_burst_counter
(
   // Clock and synchronised reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Counter side of the burst interface
   sbcd_burst_if.cnt bus
);
   import sbcd_pkg::*;

   logic [SBCD_ADDR_W-1:0] base_reg;  // Start address of the burst
   logic [SBCD_ADDR_W-1:0] base_next;
   logic [SBCD_ADDR_W-1:0] count_reg; // Beats taken so far, wraps
   logic [SBCD_ADDR_W-1:0] count_next;

   // Next base and count
   always_comb
   begin
      base_next = base_reg;
      count_next = count_reg;
      if (bus.load)
      begin
         // New burst starts at the external address
         base_next = bus.start;
         count_next = SBCD_ADDR_RST;
      end
      else if (bus.step)
      begin
         // Wraps after four beats by width alone
         count_next = count_reg + 2'h1;
      end
   end

   // Register the counter
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         base_reg <= SBCD_ADDR_RST;
         count_reg <= SBCD_ADDR_RST;
      end
      else
      begin
         base_reg <= base_next;
         count_reg <= count_next;
      end
   end

   // Interleaved order is an XOR of the count, linear is a wrapping sum
   assign bus.addr = bus.linear ? (base_next + count_next) : (base_next ^ count_next);
endmodule

// File: design/sbcd_top.sv
/*
 * Cycle decoder of a pipelined burst SRAM: samples strobes, chip selects,
 * advance and write inputs on each rising edge and reports the cycle in effect,
 * its burst address, the byte lanes written and the data pin direction.
 * Assumes all control inputs are synchronous to i_clock except the output enable,
 * which is asynchronous and only gates the registered read drive.
 */
`timescale 1ns/1ps

// Summary of operation
// - Controller strobe start with write: accept data
// - Controller strobe start read, drive when enabled
// - Continue read at next burst address
// - Continue write at next burst address
// - Suspend read repeats current address
// - Suspend write stores at current address
// - Byte selects pick lanes with parity
// - Eight selects; narrower parts use fewer
// - Any select combination written together
// - Global write low writes every lane
// - Processor strobe starts are always reads
// - Two-bit counter, interleaved or linear order
// - Output enable asynchronous, masked during writes
module sbcd_top
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_arst_n,
   // Address strobes and advance
   input wire logic i_processor_addr_strobe_n,
   input wire logic i_controller_addr_strobe_n,
   input wire logic i_burst_advance_n,
   // Chip selects and sleep
   input wire logic i_chip_select_primary_n,
   input wire logic i_chip_select_expand_hi,
   input wire logic i_chip_select_expand_n,
   input wire logic i_sleep_request,
   // Write controls
   input wire logic i_global_write_n,
   input wire logic i_byte_write_enable_n,
   input wire logic [sbcd_pkg::SBCD_LANES-1:0] i_byte_lane_select_n,
   // Address low bits and burst order
   input wire logic [sbcd_pkg::SBCD_ADDR_W-1:0] i_addr_low,
   input wire logic i_burst_order_linear,
   // Asynchronous output enable
   input wire logic i_output_enable_n,
   // Decoded cycle
   output logic o_cycle_active,
   output logic o_cycle_write,
   output logic [sbcd_pkg::SBCD_ADDR_W-1:0] o_burst_addr,
   output logic [sbcd_pkg::SBCD_LANES-1:0] o_lane_write,
   output logic o_accept_data,
   output logic o_data_drive
);
   import sbcd_pkg::*;

   // Reset synchroniser; first stage feeds only the second
   logic rst_meta_reg;
   logic rst_n_reg;

   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   // Burst counter connection
   sbcd_burst_if burst ();

   sbcd_burst_counter u_counter
   (
      .i_clock (i_clock),
      .i_rst_n (rst_n_reg),
      .bus (burst)
   );

   // Decoded conditions of this edge
   logic chip_selected;    // All three selects active
   logic start_ctrl;       // Controller strobe start
   logic start_proc;       // Processor strobe start
   logic hold_ok;          // Continue or suspend strobe pattern
   logic write_low;        // Derived write signal is low
   logic [SBCD_LANES-1:0] lanes_sel; // Lanes written if this is a write

   // Cycle state
   sbcd_cycle_t cycle_reg;
   sbcd_cycle_t cycle_next;
   logic [SBCD_LANES-1:0] lane_reg;
   logic [SBCD_LANES-1:0] lane_next;
   logic in_burst_reg;     // A burst has been started and not ended
   logic in_burst_next;

   // Strobe and write decode
   always_comb
   begin
      chip_selected = !i_chip_select_primary_n && i_chip_select_expand_hi && !i_chip_select_expand_n;
      // Controller start needs processor strobe high
      start_ctrl = !i_sleep_request && !i_controller_addr_strobe_n && i_processor_addr_strobe_n
                   && chip_selected;
      // Processor start regardless of write inputs
      start_proc = !i_sleep_request && !i_processor_addr_strobe_n && chip_selected;
      // Processor strobe high, or primary select high, with controller strobe high
      hold_ok = !i_sleep_request && i_controller_addr_strobe_n
                && (i_processor_addr_strobe_n || i_chip_select_primary_n);
      // Derived write low on global write, or byte enable with any select
      write_low = !i_global_write_n || (!i_byte_write_enable_n && !(&i_byte_lane_select_n));
      // Each low select writes its byte and parity bit, any mix at once
      if (!i_global_write_n)
      begin
         lanes_sel = SBCD_LANES_ALL;
      end
      else if (!i_byte_write_enable_n)
      begin
         // Selects are taken at this edge only
         lanes_sel = ~i_byte_lane_select_n;
      end
      else
      begin
         lanes_sel = SBCD_LANES_RST;
      end
   end

   // Next cycle and burst counter control
   always_comb
   begin
      cycle_next = SBCD_IDLE;
      lane_next = SBCD_LANES_RST;
      in_burst_next = 1'b0;
      burst.load = 1'b0;
      burst.step = 1'b0;
      burst.start = i_addr_low;
      burst.linear = i_burst_order_linear;
      if (start_proc)
      begin
         // Always a read at the external address
         cycle_next = SBCD_READ;
         in_burst_next = 1'b1;
         burst.load = 1'b1;
      end
      else if (start_ctrl)
      begin
         // Begin burst at the external address; advance ignored
         cycle_next = write_low ? SBCD_WRITE : SBCD_READ;
         lane_next = write_low ? lanes_sel : SBCD_LANES_RST;
         in_burst_next = 1'b1;
         burst.load = 1'b1;
      end
      else if (hold_ok && in_burst_reg)
      begin
         // Advance low steps high holds the address
         cycle_next = write_low ? SBCD_WRITE : SBCD_READ;
         lane_next = write_low ? lanes_sel : SBCD_LANES_RST;
         in_burst_next = 1'b1;
         burst.step = !i_burst_advance_n;
      end
   end

   // Register the cycle state
   always_ff @(posedge i_clock or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         cycle_reg <= SBCD_IDLE;
         lane_reg <= SBCD_LANES_RST;
         in_burst_reg <= 1'b0;
      end
      else
      begin
         cycle_reg <= cycle_next;
         lane_reg <= lane_next;
         in_burst_reg <= in_burst_next;
      end
   end

   // Registered outputs
   logic active_reg;
   logic write_reg;
   logic accept_reg;
   logic read_drive_reg;   // Read in effect; output enable gates it later
   logic [SBCD_ADDR_W-1:0] addr_reg;

   always_ff @(posedge i_clock or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         active_reg <= 1'b0;
         write_reg <= 1'b0;
         accept_reg <= 1'b0;
         read_drive_reg <= 1'b0;
         addr_reg <= SBCD_ADDR_RST;
      end
      else
      begin
         active_reg <= (cycle_next != SBCD_IDLE);
         write_reg <= (cycle_next == SBCD_WRITE);
         // Write data taken whatever the output enable
         accept_reg <= (cycle_next == SBCD_WRITE);
         // Drive is masked on writes so the pins stay tri-stated
         read_drive_reg <= (cycle_next == SBCD_READ);
         addr_reg <= burst.addr;
      end
   end

   assign o_cycle_active = active_reg;
   assign o_cycle_write = write_reg;
   assign o_accept_data = accept_reg;
   assign o_burst_addr = addr_reg;
   assign o_lane_write = lane_reg;
   // Output enable is never clocked, so this one gate follows it at once
   assign o_data_drive = read_drive_reg && !i_output_enable_n;

   // Checks
   sequence s_ctrl_write;
      start_ctrl && !start_proc && write_low;
   endsequence

   sequence s_step_ok;
      hold_ok && in_burst_reg && !start_ctrl && !start_proc;
   endsequence

   a_ctrl_write_start: assert property (@(posedge i_clock) disable iff (!rst_n_reg)
      s_ctrl_write |=> o_cycle_write && o_accept_data && o_burst_addr == $past(i_addr_low))
      else $error("controller write start not taken");

   a_ctrl_read_start: assert property (@(posedge i_clock) disable iff (!rst_n_reg)
      start_ctrl && !start_proc && !write_low |=> o_cycle_active && !o_cycle_write)
      else $error("controller read start not taken");

   a_continue_step: assert property (@(posedge i_clock) disable iff (!rst_n_reg)
      (s_step_ok and (!i_burst_advance_n && i_burst_order_linear))
      |=> o_burst_addr == $past(o_burst_addr) + 2'h1)
      else $error("linear continue did not step");

   a_continue_write: assert property (@(posedge i_clock) disable iff (!rst_n_reg)
      (s_step_ok and write_low) |=> o_accept_data && o_lane_write != SBCD_LANES_RST)
      else $error("continue write not accepted");

   a_suspend_hold: assert property (@(posedge i_clock) disable iff (!rst_n_reg)
      (s_step_ok and i_burst_advance_n) |=> $stable(o_burst_addr))
      else $error("suspend moved the address");

   a_byte_lanes: assert property (@(posedge i_clock) disable iff (!rst_n_reg)
      (s_ctrl_write and i_global_write_n) |=> o_lane_write == ~$past(i_byte_lane_select_n))
      else $error("byte lanes wrong");

   a_global_all: assert property (@(posedge i_clock) disable iff (!rst_n_reg)
      (s_ctrl_write and !i_global_write_n) |=> o_lane_write == SBCD_LANES_ALL)
      else $error("global write missed lanes");

   a_proc_read: assert property (@(posedge i_clock) disable iff (!rst_n_reg)
      start_proc |=> o_cycle_active && !o_cycle_write && o_lane_write == SBCD_LANES_RST)
      else $error("processor start was not a read");

   // First step after a start: interleaved flips bit 0 only, linear would carry into bit 1 from an odd start
   a_interleave: assert property (@(posedge i_clock) disable iff (!rst_n_reg)
      (start_ctrl || start_proc) ##1 (s_step_ok and (!i_burst_advance_n && !i_burst_order_linear))
      |=> o_burst_addr == ($past(i_addr_low, 2) ^ 2'h1))
      else $error("interleaved order wrong");

   a_write_no_drive: assert property (@(posedge i_clock) disable iff (!rst_n_reg)
      o_cycle_write |-> !o_data_drive)
      else $error("pins driven during write");
endmodule

// File: bench/sbcd_ctrl_model.sv
/*
 * Memory controller model that drives the decoder's synchronous controls.
 * Assumes one shared clock; output enable is asynchronous and set directly.
 */
`timescale 1ns/1ps
module sbcd_ctrl_model
(
   // Shared clock
   input wire logic i_clock,
   // Strobes, advance, selects, sleep
   output logic o_ctrl_stb_n,
   output logic o_proc_stb_n,
   output logic o_advance_n,
   output logic [2:0] o_sel,
   output logic o_sleep,
   // Write controls and address
   output logic o_gwrite_n,
   output logic o_bytes_en_n,
   output logic [7:0] o_lane_n,
   output logic [1:0] o_addr,
   output logic o_linear,
   // Asynchronous output enable
   output logic o_oe_n
);
   // Everything inactive and deselected at time zero
   initial
   begin
      {o_ctrl_stb_n, o_proc_stb_n, o_advance_n, o_sleep} = 4'hE;
      o_sel = 3'h6;
      {o_gwrite_n, o_bytes_en_n, o_linear, o_oe_n} = 4'hF;
      o_lane_n = 8'hFF;
      o_addr = 2'h0;
   end

   // One bus cycle, changed only just after a rising edge
   task automatic step(input logic cs_n, ps_n, adv_n, input logic [2:0] ce, input logic zz, gw_n, bwe_n,
                       input logic [7:0] bw_n, input logic [1:0] a, input logic lin);
      @(posedge i_clock);
      o_ctrl_stb_n <= cs_n;
      o_proc_stb_n <= ps_n;
      o_advance_n <= adv_n;
      o_sel <= ce;
      o_sleep <= zz;
      o_gwrite_n <= gw_n;
      o_bytes_en_n <= bwe_n;
      o_lane_n <= bw_n;
      o_addr <= a;
      o_linear <= lin;
   endtask

   // Output enable is not clocked, so it may move anywhere in a cycle
   task automatic set_oe(input logic v);
      o_oe_n = v;
   endtask
endmodule

// File: bench/tb.sv
/*
 * Self-checking bench of the burst cycle decoder.
 * Assumes the decoder answers just after the sampling edge.
 */
`timescale 1ns/1ps
module tb;
   import sbcd_pkg::*;
   // Chip select sets {primary_n, expand_hi, expand_n}
   localparam logic [2:0] CE_ON = 3'h2;
   localparam logic [2:0] CE_OFF = 3'h6;
   // Idle checks ignore the held burst address
   localparam logic [13:0] IDLE_M = 14'h33FF;
   logic clock, arst_n, cs_n, ps_n, adv_n, zz, gw_n, bwe_n, lin, oe_n;
   logic [2:0] ce;
   logic [7:0] bw_n;
   logic [1:0] a;
   logic act, wr, acc, drv;
   logic [1:0] baddr;
   logic [7:0] lanes;
   logic [13:0] obs;
   int miscompares = 0;
   int check_count = 0;

   assign obs = {act, wr, baddr, lanes, acc, drv};

   // 250 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   sbcd_ctrl_model ctl (.i_clock(clock), .o_ctrl_stb_n(cs_n), .o_proc_stb_n(ps_n), .o_advance_n(adv_n),
      .o_sel(ce), .o_sleep(zz), .o_gwrite_n(gw_n), .o_bytes_en_n(bwe_n), .o_lane_n(bw_n), .o_addr(a),
      .o_linear(lin), .o_oe_n(oe_n));

   sbcd_top dut (.i_clock(clock), .i_arst_n(arst_n), .i_processor_addr_strobe_n(ps_n),
      .i_controller_addr_strobe_n(cs_n), .i_burst_advance_n(adv_n), .i_chip_select_primary_n(ce[2]),
      .i_chip_select_expand_hi(ce[1]), .i_chip_select_expand_n(ce[0]), .i_sleep_request(zz),
      .i_global_write_n(gw_n), .i_byte_write_enable_n(bwe_n), .i_byte_lane_select_n(bw_n),
      .i_addr_low(a), .i_burst_order_linear(lin), .i_output_enable_n(oe_n), .o_cycle_active(act),
      .o_cycle_write(wr), .o_burst_addr(baddr), .o_lane_write(lanes), .o_accept_data(acc),
      .o_data_drive(drv));

   // Packs an expected output set
   function automatic logic [13:0] e(input logic ac, w, input logic [1:0] ad, input logic [7:0] ln,
                                     input logic ad_ok, dr);
      return {ac, w, ad, ln, ad_ok, dr};
   endfunction

   // Single comparison point
   task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t saw %h want %h", $time, seen, exp);
      end
   endtask

   // Deselect cycle: primary select high with controller strobe low
   task automatic idle();
      ctl.step(0, 1, 1, CE_OFF, 0, 1, 1, 8'hFF, 2'h0, 1);
   endtask

   // Byte write burst, linear wrap, suspend; output enable low but masked
   task automatic t_write_burst();
      ctl.set_oe(0);
      ctl.step(0, 1, 1, CE_ON, 0, 1, 0, 8'hA5, 2'h3, 1);
      ctl.step(1, 1, 0, CE_ON, 0, 1, 0, 8'hA5, 2'h0, 1);
      #1 chk(obs, e(1, 1, 2'h3, 8'h5A, 1, 0));
      ctl.step(1, 1, 1, CE_ON, 0, 1, 0, 8'hA5, 2'h0, 1);
      #1 chk(obs, e(1, 1, 2'h0, 8'h5A, 1, 0));
      idle();
      #1 chk(obs, e(1, 1, 2'h0, 8'h5A, 1, 0));
   endtask

   // Interleaved read burst from an odd start, so the order differs from linear
   task automatic t_read_burst();
      ctl.step(0, 1, 1, CE_ON, 0, 1, 1, 8'hFF, 2'h1, 0);
      ctl.step(1, 0, 0, CE_OFF, 0, 1, 1, 8'hFF, 2'h0, 0);
      #1 chk(obs, e(1, 0, 2'h1, 8'h00, 0, 1));
      ctl.set_oe(1);
      #1 chk(obs, e(1, 0, 2'h1, 8'h00, 0, 0));
      ctl.set_oe(0);
      ctl.step(1, 1, 1, CE_ON, 0, 1, 1, 8'hFF, 2'h0, 0);
      #1 chk(obs, e(1, 0, 2'h0, 8'h00, 0, 1));
      ctl.step(1, 1, 0, CE_ON, 0, 1, 1, 8'hFF, 2'h0, 0);
      #1 chk(obs, e(1, 0, 2'h0, 8'h00, 0, 1));
      idle();
      #1 chk(obs, e(1, 0, 2'h3, 8'h00, 0, 1));
   endtask

   // Processor start with global write low is still a read; next clock writes
   task automatic t_proc_start();
      ctl.step(1, 0, 1, CE_ON, 0, 0, 0, 8'h00, 2'h1, 1);
      ctl.step(1, 1, 0, CE_ON, 0, 0, 1, 8'hFF, 2'h0, 1);
      #1 chk(obs, e(1, 0, 2'h1, 8'h00, 0, 1));
      idle();
      #1 chk(obs, e(1, 1, 2'h2, 8'hFF, 1, 0));
   endtask

   // Back-to-back starts over every lane and the write input decode table
   task automatic t_lanes();
      logic [13:0] pv;
      logic [7:0] s, ln;
      logic g, b, w;
      ctl.set_oe(1);
      for (int k = 0; k < 12; k++)
      begin
         g = (k != 9);
         b = (k >= 9) && (k != 11);
         s = (k < 8) ? ~(8'h01 << k) : ((k == 8 || k == 10) ? 8'h00 : 8'hFF);
         ctl.step(0, 1, 1, CE_ON, 0, g, b, s, k[1:0], 1);
         if (k > 0)
            #1 chk(obs, pv);
         w = !g || (!b && s != 8'hFF);
         ln = !g ? 8'hFF : (w ? ~s : 8'h00);
         pv = e(1, w, k[1:0], ln, w, 0);
      end
      idle();
      #1 chk(obs, pv);
   endtask

   // Continue with no burst, and sleep ending a burst, both go idle
   task automatic t_refused();
      idle();
      ctl.step(1, 1, 0, CE_ON, 0, 1, 1, 8'hFF, 2'h0, 1);
      #1 chk(obs & IDLE_M, 14'h0000);
      ctl.step(0, 1, 1, CE_ON, 0, 1, 1, 8'hFF, 2'h1, 1);
      #1 chk(obs & IDLE_M, 14'h0000);
      ctl.step(1, 1, 0, CE_ON, 1, 1, 1, 8'hFF, 2'h0, 1);
      #1 chk(obs, e(1, 0, 2'h1, 8'h00, 0, 0));
      ctl.step(1, 1, 0, CE_ON, 0, 1, 1, 8'hFF, 2'h0, 1);
      #1 chk(obs & IDLE_M, 14'h0000);
      idle();
      #1 chk(obs & IDLE_M, 14'h0000);
   endtask

   // Verdict and end of run
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Watchdog well beyond the roughly 35 cycles of stimulus
   initial
   begin
      repeat (2000) @(posedge clock);
      miscompares++;
      wrap_up();
   end

   // Reset for two cycles, wait out the release flops, then scenarios
   initial
   begin
      arst_n = 1'b0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) idle();
      t_write_burst();
      t_read_burst();
      t_proc_start();
      t_lanes();
      t_refused();
      wrap_up();
   end
endmodule
